// *** src/adc_seq_pkg.sv ***
// Constants shared by the conversion sequencer design files.
package adc_seq_pkg;
    // Register word offsets on the plain register port.
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_CHAN    = 4'h1;
    localparam logic [3:0] OFF_EN_TIME = 4'h2;
    localparam logic [3:0] OFF_SMP_TIME = 4'h3;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_IRQ_ST  = 4'h5;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
    localparam logic [3:0] OFF_RESULT  = 4'h7;
    localparam logic [3:0] OFF_AUTO_BASE = 4'h8;
    // Control register field positions.
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CONT_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    // Reset values.
    localparam logic [7:0] EN_TIME_RST  = 8'h10;
    localparam logic [7:0] SMP_TIME_RST = 8'h04;
    // Timing in clock cycles.
    localparam int CONVERT_CYCLES = 12;
    localparam int IRQ_WIDTH_CYCLES = 2;
    // Channel layout.
    localparam int AUTO_FIRST_CH = 0;
    localparam int AUTO_LAST_CH  = 11;
    localparam int RESULT_BITS   = 10;
    // Operating modes.
    typedef enum logic [1:0] {
        MODE_SINGLE  = 2'h0,
        MODE_ROUND   = 2'h1,
        MODE_ONETIME = 2'h2
    } mode_t;
endpackage : adc_seq_pkg

// *** src/adc_phase_timer.sv ***
// Down counter that times one phase of the sequence and flags its last cycle.
`timescale 1ns/10ps
module adc_phase_timer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    // Control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] count_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] cnt_q;

    // Load the phase length, then count down and hold at zero; done flags the count of one, the final cycle.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done_o = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : adc_phase_timer

// *** src/adc_result_bank.sv ***
// Per-channel result storage for the automatic readout modes.
`timescale 1ns/10ps
module adc_result_bank #(
    parameter int CHANNELS = 12,
    parameter int DW       = 10
) (
    // Clock and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        sys_rst_i,
    // Write side
    input  wire logic                        wr_i,
    input  wire logic [3:0]                  wr_idx_i,
    input  wire logic [DW-1:0]               wr_data_i,
    // Read side
    input  wire logic [3:0]                  rd_idx_i,
    output logic      [DW-1:0]               rd_data_o
);
    logic [DW-1:0] mem_q [CHANNELS];

    // Each entry is overwritten by the newest result for its channel.
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ent
        always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                mem_q[g] <= '0;
            end else if (wr_i && (wr_idx_i == 4'(g))) begin
                mem_q[g] <= wr_data_i;
            end
        end
    end

    // Reads are side-effect free and never stall the writer.
    assign rd_data_o = (rd_idx_i < 4'(CHANNELS)) ? mem_q[rd_idx_i] : '0;
endmodule : adc_result_bank

// *** src/adc_conversion_sequencer.sv ***
// Sequencer that drives the SAR converter and presents results to the core.
`timescale 1ns/10ps
// How it works
// - Three modes: single channel, round-robin automatic, one-time automatic.
// - Single mode converts only the selected channel, then interrupts the core.
// - After enable rises, wait the programmed enable time before sampling.
// - Sampling lasts the programmed sample time before conversion starts.
// - Conversion lasts exactly twelve clock cycles until the result is ready.
// - At conversion end the result is readable and the pulse lasts two cycles.
// - Continuous single mode resamples the same channel after the pulse.
// - Round-robin converts channels zero to eleven, storing each per channel.
// - Result registers for channels zero to seven stay readable any time without disturbing the sequence.
// - Round-robin restarts continuously; new results overwrite old ones.
// - One-time mode stops after the last channel and interrupts once.
// - Every conversion result is ten bits wide.
// - The converter can take and convert just one sampled value.
module adc_conversion_sequencer #(
    parameter int CH_BITS = 5
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 sys_rst_i,
    // Register port
    input  wire logic [3:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [15:0]          reg_rdata_o,
    // Analog converter side
    output logic                      conv_sample_o,
    output logic                      conv_start_o,
    output logic      [CH_BITS-1:0]   conv_chan_o,
    input  wire logic [9:0]           conv_data_i,
    // Core side
    output logic                      completion_irq_o,
    output logic                      irq_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ENWAIT, ST_SAMPLE, ST_CONVERT, ST_IRQ, ST_DONE
    } state_t;

    // Software registers.
    logic                 en_q;
    logic                 cont_q;
    logic [1:0]           mode_q;
    logic [CH_BITS-1:0]   sel_chan_q;
    logic [7:0]           en_time_q;
    logic [7:0]           smp_time_q;
    logic [1:0]           irq_st_q;
    logic [1:0]           irq_mask_q;
    logic [9:0]           result_q;
    logic [15:0]          rdata_q;
    // Sequencer state.
    state_t               state_q;
    state_t               state_d;
    logic [CH_BITS-1:0]   chan_q;
    logic [CH_BITS-1:0]   chan_d;
    logic                 en_prev_q;
    logic                 sample_q;
    logic                 start_q;
    logic                 cirq_q;
    logic                 irq_q;

    // Register decode.
    wire wr_ctrl   = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_CTRL);
    wire wr_chan   = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_CHAN);
    wire wr_entime = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_EN_TIME);
    wire wr_smp    = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_SMP_TIME);
    wire wr_irqst  = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_IRQ_ST);
    wire wr_mask   = reg_wr_i && (reg_addr_i == adc_seq_pkg::OFF_IRQ_MASK);
    wire auto_mode = (mode_q == adc_seq_pkg::MODE_ROUND) ||
                     (mode_q == adc_seq_pkg::MODE_ONETIME);
    wire rise_en   = en_q && !en_prev_q;

    // Phase timer.
    wire       t_load;
    wire [7:0] t_count;
    wire       t_done;
    wire       last_ch = (chan_q == CH_BITS'(adc_seq_pkg::AUTO_LAST_CH));
    wire       conv_end = (state_q == ST_CONVERT) && t_done && en_q;
    wire       irq_end  = (state_q == ST_IRQ) && t_done && en_q;
    wire [3:0] bank_rd_idx = reg_addr_i - adc_seq_pkg::OFF_AUTO_BASE;
    wire [9:0] bank_rd_data;

    assign t_load  = (state_d != state_q);
    assign t_count = (state_d == ST_ENWAIT) ? en_time_q :
                     (state_d == ST_SAMPLE) ? smp_time_q :
                     (state_d == ST_CONVERT) ? 8'(adc_seq_pkg::CONVERT_CYCLES) :
                     8'(adc_seq_pkg::IRQ_WIDTH_CYCLES);

    adc_phase_timer #(
        .WIDTH     (8)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (t_load),
        .count_i   (t_count),
        .done_o    (t_done)
    );

    adc_result_bank #(
        .CHANNELS  (adc_seq_pkg::AUTO_LAST_CH + 1),
        .DW        (adc_seq_pkg::RESULT_BITS)
    ) u_bank (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .wr_i      (conv_end && auto_mode),
        .wr_idx_i  (chan_q[3:0]),
        .wr_data_i (conv_data_i),
        .rd_idx_i  (bank_rd_idx),
        .rd_data_o (bank_rd_data)
    );

    // Next-state logic for the conversion sequence.
    always_comb begin
        state_d = state_q;
        chan_d  = chan_q;
        unique case (state_q)
            ST_IDLE: begin
                if (rise_en) begin
                    state_d = ST_ENWAIT;
                    chan_d  = auto_mode ? CH_BITS'(adc_seq_pkg::AUTO_FIRST_CH) : sel_chan_q;
                end
            end
            ST_ENWAIT: begin
                if (t_done || en_time_q <= 8'h01) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (t_done || smp_time_q <= 8'h01) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (t_done) begin
                    state_d = ST_IRQ;
                end
            end
            ST_IRQ: begin
                if (t_done) begin
                    if (auto_mode && !last_ch) begin
                        state_d = ST_SAMPLE;
                        chan_d  = chan_q + 1'b1;
                    end else if (mode_q == adc_seq_pkg::MODE_ROUND) begin
                        state_d = ST_SAMPLE;
                        chan_d  = CH_BITS'(adc_seq_pkg::AUTO_FIRST_CH);
                    end else if (!auto_mode && cont_q) begin
                        state_d = ST_SAMPLE;
                        chan_d  = sel_chan_q;
                    end else begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
        endcase
        if (!en_q) begin
            state_d = ST_IDLE;
        end
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q   <= ST_IDLE;
            chan_q    <= '0;
            en_prev_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            chan_q    <= chan_d;
            en_prev_q <= en_q;
        end
    end

    // Converter strobes and the two-cycle completion pulse, all registered.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sample_q <= 1'b0;
            start_q  <= 1'b0;
            cirq_q   <= 1'b0;
        end else begin
            sample_q <= (state_d == ST_SAMPLE);
            start_q  <= (state_d == ST_CONVERT);
            // Single mode pulses every conversion; one-time pulses only at the end.
            cirq_q   <= (state_d == ST_IRQ) && en_q &&
                        (!auto_mode || (mode_q == adc_seq_pkg::MODE_ONETIME && last_ch));
        end
    end

    // Latest result register, updated at each conversion end.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_q <= '0;
        end else if (conv_end) begin
            result_q <= conv_data_i;
        end
    end

    // Control registers written by software.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_q       <= 1'b0;
            cont_q     <= 1'b0;
            mode_q     <= adc_seq_pkg::MODE_SINGLE;
            sel_chan_q <= '0;
            en_time_q  <= adc_seq_pkg::EN_TIME_RST;
            smp_time_q <= adc_seq_pkg::SMP_TIME_RST;
            irq_mask_q <= '0;
        end else begin
            if (wr_ctrl) begin
                en_q   <= reg_wdata_i[adc_seq_pkg::CTRL_EN_BIT];
                cont_q <= reg_wdata_i[adc_seq_pkg::CTRL_CONT_BIT];
                mode_q <= reg_wdata_i[adc_seq_pkg::CTRL_MODE_LSB +: 2];
            end
            if (wr_chan) begin
                sel_chan_q <= reg_wdata_i[CH_BITS-1:0];
            end
            if (wr_entime) begin
                en_time_q <= reg_wdata_i[7:0];
            end
            if (wr_smp) begin
                smp_time_q <= reg_wdata_i[7:0];
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata_i[1:0];
            end
        end
    end

    // Sticky status: bit0 single-mode conversion done, bit1 one-time pass done; set wins over clear.
    wire [1:0] irq_set = {irq_end && mode_q == adc_seq_pkg::MODE_ONETIME && last_ch,
                          conv_end && !auto_mode};
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_st_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~(wr_irqst ? reg_wdata_i[1:0] : 2'h0)) | irq_set;
            irq_q    <= |(((irq_st_q & ~(wr_irqst ? reg_wdata_i[1:0] : 2'h0)) | irq_set)
                          & irq_mask_q);
        end
    end

    // Read mux; data stand one cycle after the read strobe.
    wire [15:0] rd_mux =
        (reg_addr_i == adc_seq_pkg::OFF_CTRL)     ? {12'h000, mode_q, cont_q, en_q} :
        (reg_addr_i == adc_seq_pkg::OFF_CHAN)     ? 16'(sel_chan_q) :
        (reg_addr_i == adc_seq_pkg::OFF_EN_TIME)  ? {8'h00, en_time_q} :
        (reg_addr_i == adc_seq_pkg::OFF_SMP_TIME) ? {8'h00, smp_time_q} :
        (reg_addr_i == adc_seq_pkg::OFF_STATUS)   ? {8'h00, 3'(chan_q), 2'h0, 3'(state_q)} :
        (reg_addr_i == adc_seq_pkg::OFF_IRQ_ST)   ? {14'h0000, irq_st_q} :
        (reg_addr_i == adc_seq_pkg::OFF_IRQ_MASK) ? {14'h0000, irq_mask_q} :
        (reg_addr_i == adc_seq_pkg::OFF_RESULT)   ? {6'h00, result_q} :
        {6'h00, bank_rd_data};
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata_o      = rdata_q;
    assign conv_sample_o    = sample_q;
    assign conv_start_o     = start_q;
    assign conv_chan_o      = chan_q;
    assign completion_irq_o = cirq_q;
    assign irq_o            = irq_q;

    // Helper count of consecutive conversion cycles; a counter keeps the length check cheap.
    logic [3:0] conv_cnt_q;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_cnt_q <= 4'h0;
        end else if (conv_start_o) begin
            conv_cnt_q <= conv_cnt_q + 4'h1;
        end else begin
            conv_cnt_q <= 4'h0;
        end
    end

    // A finished single-mode conversion, then the two-cycle pulse that reports it.
    sequence conv_done_s;
        $fell(conv_start_o) && en_q && !auto_mode;
    endsequence
    sequence pulse_two_s;
        completion_irq_o [*2] ##1 !completion_irq_o;
    endsequence

    // Conversion phase lasts exactly twelve cycles.
    conv_len_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $fell(conv_start_o) && en_q |-> conv_cnt_q == 4'(adc_seq_pkg::CONVERT_CYCLES))
        else $error("conversion length wrong");
    // The conversion strobe never outlasts its twelve cycles.
    conv_max_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        conv_cnt_q <= 4'(adc_seq_pkg::CONVERT_CYCLES))
        else $error("conversion strobe too long");
    // Completion pulse stays high for a second cycle unless enable drops.
    irq_width_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(completion_irq_o) |-> completion_irq_o ##1 (completion_irq_o || !en_q))
        else $error("completion pulse too short");
    // Disable returns to idle in one cycle.
    dis_idle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !en_q |=> state_q == ST_IDLE && !completion_irq_o)
        else $error("disable did not abandon");
    // Round robin channel never passes eleven.
    chan_range_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        auto_mode && state_q != ST_IDLE |-> chan_q <= 5'd11)
        else $error("auto channel out of range");
    // Sampling precedes conversion directly.
    smp_conv_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $fell(conv_sample_o) && en_q |-> conv_start_o)
        else $error("conversion did not follow sample");
    // Each single-mode conversion is reported by exactly two pulse cycles.
    irq_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        conv_done_s |-> pulse_two_s)
        else $error("completion pulse not two cycles");
    // A single-mode result always sets its sticky status bit, even against a clear.
    status_set_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        conv_end && !auto_mode |=> irq_st_q[0])
        else $error("status bit not set");
    // Round robin wraps from the last channel back to the first and keeps going.
    rr_wrap_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        irq_end && (mode_q == adc_seq_pkg::MODE_ROUND) && last_ch |=>
            (state_q == ST_SAMPLE) && (chan_q == CH_BITS'(adc_seq_pkg::AUTO_FIRST_CH)))
        else $error("round robin did not wrap");
    // The interrupt line follows the status bits through the mask.
    irq_level_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        irq_o == |(irq_st_q & $past(irq_mask_q)))
        else $error("interrupt line wrong");
    // Once a pass has halted, the converter strobes stay quiet.
    onetime_halt_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        state_q == ST_DONE |-> !conv_sample_o && !conv_start_o)
        else $error("strobes active after halt");
endmodule : adc_conversion_sequencer

// *** testbench/adc_conv_model.sv ***
// Behavioural model of the SAR converter that answers the sequencer.
`timescale 1ns/10ps
module adc_conv_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Sequencer side
    input  wire logic       conv_start_i,
    input  wire logic [4:0] conv_chan_i,
    input  wire logic [9:0] bias_i,
    output logic      [9:0] conv_data_o
);
    logic [9:0] data_q = 10'h155;
    // The result tracks the channel while converting and toggles otherwise, so stale data shows.
    always @(posedge ref_clk_i) begin
        if (conv_start_i) begin
            data_q <= {conv_chan_i, ~conv_chan_i} ^ bias_i;
        end else begin
            data_q <= ~data_q;
        end
    end
    assign conv_data_o = data_q;
endmodule : adc_conv_model

// *** testbench/tb_adc_conversion_sequencer.sv ***
// Self-checking bench for the conversion sequencer with a converter model.
`timescale 1ns/10ps
module tb_adc_conversion_sequencer;
    logic        ref_clk_i   = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        conv_sample_o, conv_start_o, completion_irq_o, irq_o;
    logic [4:0]  conv_chan_o;
    logic [9:0]  conv_data_i;
    logic [9:0]  bias_q      = 10'h000;
    logic [15:0] seed_q      = 16'h773c;
    logic [15:0] rd_q;
    logic [4:0]  ch;
    logic [4:0]  chan_q[$];
    logic        skip_q      = 1'b0;
    int          error_cnt   = 0;
    int          compares    = 0;
    int          cyc = 0, s_run = 0, c_run = 0, i_run = 0, irq_done = 0;
    int          t_samp = 0, t_wr = 0, smp_exp = 4, en_t = 16, base = 0;

    // Free-running core clock.
    always #20 ref_clk_i = ~ref_clk_i;

    adc_conversion_sequencer adc_conversion_sequencer_inst (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .conv_sample_o(conv_sample_o), .conv_start_o(conv_start_o),
        .conv_chan_o(conv_chan_o), .conv_data_i(conv_data_i),
        .completion_irq_o(completion_irq_o), .irq_o(irq_o));
    adc_conv_model adc_conv_model_inst (
        .ref_clk_i(ref_clk_i), .conv_start_i(conv_start_o), .conv_chan_i(conv_chan_o),
        .bias_i(bias_q), .conv_data_o(conv_data_i));

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    function automatic logic [15:0] exp_data(input logic [4:0] c);
        return {6'h00, c, ~c} ^ {6'h00, bias_q};
    endfunction : exp_data

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1 t_wr = cyc;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_q = reg_rdata_o;
    endtask : rd

    // Waits for a pulse count (sel 0) or a converted-channel count (sel 1), bounded.
    task automatic wait_until(input int n, input int sel);
        for (int i = 0; i < 3000; i++) begin
            @(negedge ref_clk_i);
            if ((sel == 0 ? irq_done : chan_q.size()) >= n) return;
        end
        error_cnt++;
        $display("wrong value at %0t: wait timed out", $time);
        report_and_stop();
    endtask : wait_until

    // Measures phase lengths, records converted channels and counts completion pulses.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (conv_sample_o === 1'b1) begin
            if (s_run == 0) t_samp = cyc;
            s_run++;
        end else if (s_run != 0) begin
            chk(16'(s_run), 16'(smp_exp));
            s_run = 0;
        end
        if (conv_start_o === 1'b1) begin
            if (c_run == 0) chan_q.push_back(conv_chan_o);
            c_run++;
        end else if (c_run != 0) begin
            if (!skip_q) chk(16'(c_run), 16'(adc_seq_pkg::CONVERT_CYCLES));
            c_run = 0;
        end
        if (completion_irq_o === 1'b1) begin
            i_run++;
        end else if (i_run != 0) begin
            chk(16'(i_run), 16'(adc_seq_pkg::IRQ_WIDTH_CYCLES));
            i_run = 0;
            irq_done++;
        end
    end

    // Main sequence: reset values, single shots, interrupt, continuous, abort, automatic modes.
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(adc_seq_pkg::OFF_EN_TIME);
        chk(rd_q, {8'h00, adc_seq_pkg::EN_TIME_RST});
        rd(adc_seq_pkg::OFF_SMP_TIME);
        chk(rd_q, {8'h00, adc_seq_pkg::SMP_TIME_RST});
        for (int k = 0; k < 4; k++) begin
            seed_q = lfsr_next(seed_q);
            en_t = 1 + int'(seed_q[2:0]);
            smp_exp = 1 + int'(seed_q[4:3]);
            ch = seed_q[9:5];
            bias_q = seed_q[15:6];
            wr(adc_seq_pkg::OFF_EN_TIME, 16'(en_t));
            wr(adc_seq_pkg::OFF_SMP_TIME, 16'(smp_exp));
            wr(adc_seq_pkg::OFF_CHAN, {11'h000, ch});
            chan_q.delete();
            base = irq_done;
            wr(adc_seq_pkg::OFF_CTRL, 16'h0001);
            wait_until(base + 1, 0);
            chk(16'(t_samp - t_wr), 16'(en_t + 2));
            repeat (30) @(negedge ref_clk_i);
            chk(16'(chan_q.size()), 16'h0001);
            chk({11'h000, chan_q[0]}, {11'h000, ch});
            rd(adc_seq_pkg::OFF_RESULT);
            chk(rd_q, exp_data(ch));
            wr(adc_seq_pkg::OFF_CTRL, 16'h0000);
        end
        // Status stays set; the line follows the mask and drops on a write of one.
        wr(adc_seq_pkg::OFF_IRQ_MASK, 16'h0000);
        repeat (3) @(negedge ref_clk_i);
        chk({15'h0000, irq_o}, 16'h0000);
        wr(adc_seq_pkg::OFF_IRQ_MASK, 16'h0001);
        repeat (3) @(negedge ref_clk_i);
        chk({15'h0000, irq_o}, 16'h0001);
        wr(adc_seq_pkg::OFF_IRQ_ST, 16'h0001);
        repeat (3) @(negedge ref_clk_i);
        chk({15'h0000, irq_o}, 16'h0000);
        rd(adc_seq_pkg::OFF_IRQ_ST);
        chk(rd_q & 16'h0001, 16'h0000);
        // Continuous single channel, then a disable in mid-conversion.
        wr(adc_seq_pkg::OFF_CHAN, 16'h0003);
        chan_q.delete();
        base = irq_done;
        wr(adc_seq_pkg::OFF_CTRL, 16'h0003);
        wait_until(base + 3, 0);
        for (int i = 0; i < 3; i++) chk({11'h000, chan_q[i]}, 16'h0003);
        wait_until(chan_q.size() + 1, 1);
        skip_q = 1'b1;
        wr(adc_seq_pkg::OFF_CTRL, 16'h0000);
        base = irq_done;
        repeat (40) @(negedge ref_clk_i);
        chk(16'(irq_done - base), 16'h0000);
        chk({14'h0000, conv_start_o, conv_sample_o}, 16'h0000);
        skip_q = 1'b0;
        // Round-robin readout; averaging is fixed at one sample by construction.
        smp_exp = 2;
        wr(adc_seq_pkg::OFF_EN_TIME, 16'h0001);
        wr(adc_seq_pkg::OFF_SMP_TIME, 16'h0002);
        chan_q.delete();
        base = irq_done;
        wr(adc_seq_pkg::OFF_CTRL, 16'h0005);
        wait_until(14, 1);
        for (int i = 0; i < 14; i++) chk({11'h000, chan_q[i]}, 16'(i % 12));
        for (int n = 0; n < 8; n++) begin
            rd(4'(8 + n));
            chk(rd_q, exp_data(5'(n)));
        end
        seed_q = lfsr_next(seed_q);
        bias_q = seed_q[9:0];
        wait_until(chan_q.size() + 13, 1);
        for (int n = 0; n < 8; n++) begin
            rd(4'(8 + n));
            chk(rd_q, exp_data(5'(n)));
        end
        chk(16'(irq_done - base), 16'h0000);
        skip_q = 1'b1;
        wr(adc_seq_pkg::OFF_CTRL, 16'h0000);
        repeat (20) @(negedge ref_clk_i);
        skip_q = 1'b0;
        // One-time readout halts after the last channel with one pulse.
        wr(adc_seq_pkg::OFF_IRQ_ST, 16'h0003);
        chan_q.delete();
        base = irq_done;
        wr(adc_seq_pkg::OFF_CTRL, 16'h0009);
        wait_until(base + 1, 0);
        repeat (100) @(negedge ref_clk_i);
        chk(16'(chan_q.size()), 16'd12);
        for (int i = 0; i < 12; i++) chk({11'h000, chan_q[i]}, 16'(i));
        chk(16'(irq_done - base), 16'h0001);
        rd(adc_seq_pkg::OFF_IRQ_ST);
        chk(rd_q & 16'h0002, 16'h0002);
        report_and_stop();
    end
endmodule : tb_adc_conversion_sequencer
